// [inc/aivf_pkg.sv]
// constants, record layout and carrier structs of the analog value formatter
//
// Overview of operation
// [RULE_01] reference pair uses both channels, value in first
// [RULE_02] second channel of reference pair reads 7FFFh
// [RULE_03] compensated thermocouples use reference; break gives 7FFFh
// [RULE_04] bit 15 is the sign flag
// [RULE_05] 10Hz: 14 bits plus sign, bit 0 zero
// [RULE_06] 50/60Hz: 12 bits plus sign, bits 2:0 zero
// [RULE_07] 400Hz: 9 bits plus sign, bits 5:0 zero
// [RULE_08] temperatures are never truncated
// [RULE_09] above overdrive end outputs 7FFFh
// [RULE_10] below underdrive end outputs 8000h
// [RULE_11] power-on: +/-10V, 50Hz, diagnostics off
// [RULE_12] 16-byte record; two-channel variant uses pair 0/1 only
// [RULE_13] controller sends parameters on stop to run
// [RULE_14] runtime calls may rewrite only the second record
// [RULE_15] first record byte 0: group diagnosis enables
// [RULE_16] first record byte 1: wire-break test enables
// [RULE_17] limit process interrupt on channels 0 and 2
// [RULE_18] per-pair diagnosis on break or range overflow
// [RULE_19] second record byte 1: two-bit frequency codes
// [RULE_20] second record byte 0: interrupt enables bits 6,7
// [RULE_21] saturation applied before low-bit truncation
package aivf_pkg;
    // word format
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam int SIGN_BIT = 15;
    // frequency codes and their low-bit masks
    localparam logic [1:0] FREQ_400 = 2'h0;
    localparam logic [1:0] FREQ_60 = 2'h1;
    localparam logic [1:0] FREQ_50 = 2'h2;
    localparam logic [1:0] FREQ_10 = 2'h3;
    localparam logic [15:0] MASK_10 = 16'hFFFE;
    localparam logic [15:0] MASK_50 = 16'hFFF8;
    localparam logic [15:0] MASK_400 = 16'hFFC0;
    // record sizes and byte indices
    localparam int REC0_BYTES = 2;
    localparam int REC1_BYTES = 14;
    localparam logic [3:0] IDX_GRP = 4'h0;
    localparam logic [3:0] IDX_WB = 4'h1;
    localparam logic [3:0] IDX_IRQ = 4'h0;
    localparam logic [3:0] IDX_FREQ = 4'h1;
    localparam logic [3:0] IDX_MODE0 = 4'h2;
    localparam logic [3:0] IDX_UP0 = 4'h6;
    localparam logic [3:0] IDX_LO0 = 4'h8;
    localparam logic [3:0] IDX_UP2 = 4'hA;
    localparam logic [3:0] IDX_LO2 = 4'hC;
    localparam int MAX_PAIRS = 4;
    localparam int DIAG_IRQ_BIT = 6;
    localparam int PROC_IRQ_BIT = 7;
    localparam logic [7:0] RESERVED_MASK = 8'hF0;
    // reset values of the records
    localparam logic [7:0] RST_REC0 = 8'h00;
    localparam logic [111:0] RST_REC1 =
        112'h0080_FF7F_0080_FF7F_1919_1919_AA00;
    // measuring type codes (upper nibble of a mode byte)
    localparam logic [3:0] MT_VOLT = 4'h1;
    localparam logic [3:0] MT_CUR4 = 4'h2;
    localparam logic [3:0] MT_CUR2 = 4'h3;
    localparam logic [3:0] MT_RES = 4'h4;
    localparam logic [3:0] MT_RTD = 4'h8;
    localparam logic [3:0] MT_TC_EXT = 4'hB;
    localparam logic [3:0] MT_REFJ = 4'hF;
    // read-back selectors
    localparam logic [1:0] RD_REC0 = 2'h0;
    localparam logic [1:0] RD_REC1 = 2'h1;
    localparam logic [1:0] RD_STAT = 2'h2;

    // one raw conversion result from the front end
    typedef struct packed {
        logic [2:0] chan;
        logic [15:0] value;
        logic over;
        logic under;
        logic wire_break;
    } aivf_raw_s;

    // complete state of the formatter
    typedef struct packed {
        logic [1:0][7:0] rec0;
        logic [13:0][7:0] rec1;
        logic [15:0] refj;
        logic out_valid;
        logic [2:0] out_chan;
        logic [15:0] out_value;
        logic proc_irq;
        logic diag_irq;
        logic [3:0] diag_flags;
        logic [7:0] rd_data;
    } aivf_state_s;
endpackage

// [verilog/aivf_top.sv]
// analog input value formatter with its input fifo
`timescale 1ns/1ps
`default_nettype none

module aivf_fifo #(
    parameter int W = 22,
    parameter int DEPTH = 32
) (
    input wire logic clock,           // system clock
    input wire logic rst_n,           // synchronised reset, active low
    input wire logic in_valid,        // writer offers a word
    output logic in_ready,            // space free, from a flop
    input wire logic [W-1:0] in_data, // word written
    output logic out_valid,           // word available, from a flop
    input wire logic out_ready,       // reader takes the word
    output logic [W-1:0] out_data     // word at the head
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
        logic room;
        logic valid;
    } aivf_fifo_state_s;
    // ready must show as soon as reset lets go, so room resets high
    localparam aivf_fifo_state_s ST_RST = '{room: 1'b1, default: '0};

    aivf_fifo_state_s st_r;
    aivf_fifo_state_s st_nxt;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && st_r.room;
    assign pop = st_r.valid && out_ready;
    assign in_ready = st_r.room;
    assign out_valid = st_r.valid;
    assign out_data = mem[st_r.rptr];

    // pointer and fill bookkeeping; room is its own flop so ready is clean
    always_comb begin
        st_nxt = st_r;
        st_nxt.wptr = st_r.wptr + AW'(push);
        st_nxt.rptr = st_r.rptr + AW'(pop);
        st_nxt.count = st_r.count + CW'(push) - CW'(pop);
        st_nxt.room = (st_nxt.count != CW'(DEPTH));
        st_nxt.valid = (st_nxt.count != '0);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage has no reset; only words below count are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[st_r.wptr] <= in_data;
        end
    end
endmodule

module aivf_top #(
    parameter int NUM_PAIRS = 4,   // 4 for eight channels, 1 for two
    parameter int FIFO_DEPTH = 32  // power of two
) (
    input wire logic clock,              // 250 MHz system clock
    input wire logic nrst,               // asynchronous reset, active low
    input wire logic prm_wr,             // parameter byte write strobe
    input wire logic prm_set,            // 0 first record, 1 second
    input wire logic prm_runtime,        // write comes from runtime call
    input wire logic [3:0] prm_idx,      // byte index in the record
    input wire logic [7:0] prm_data,     // parameter byte
    input wire logic [1:0] rd_set,       // read-back selector
    input wire logic [3:0] rd_idx,       // read-back byte index
    output logic [7:0] rd_data,          // read-back byte, next cycle
    input wire logic raw_valid,          // raw result offered
    output logic raw_ready,              // fifo has room
    input wire aivf_pkg::aivf_raw_s raw, // raw result
    output logic out_valid,              // formatted word valid
    input wire logic out_ready,          // consumer takes the word
    output logic [2:0] out_chan,         // channel of the word
    output logic [15:0] out_value,       // formatted signed word
    output logic proc_irq,               // limit interrupt pulse
    output logic diag_irq,               // diagnostic interrupt pulse
    output logic [3:0] diag_flags        // per-pair diagnosis state
);
    localparam logic [7:0] PAIR_MASK = 8'((1 << NUM_PAIRS) - 1);
    localparam logic [7:0] FREQ_MASK = 8'((1 << (2 * NUM_PAIRS)) - 1);
    localparam aivf_pkg::aivf_state_s RST_STATE = '{
        rec0: {aivf_pkg::RST_REC0, aivf_pkg::RST_REC0},
        rec1: aivf_pkg::RST_REC1,
        default: '0
    };

    logic [1:0] rst_sync_r;
    logic rst_n;
    aivf_pkg::aivf_state_s s_r;
    aivf_pkg::aivf_state_s s_nxt;
    logic fifo_valid;
    logic fifo_ready;
    aivf_pkg::aivf_raw_s head;

    // reset released through two flops so release is clock aligned
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // buffers bursts from the converter while the consumer stalls
    aivf_fifo #(
        .W($bits(aivf_pkg::aivf_raw_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(raw_valid),
        .in_ready(raw_ready),
        .in_data(raw),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(head)
    );

    assign fifo_ready = !s_r.out_valid || out_ready;

    // measuring type of a pair, from its mode byte
    function automatic logic [3:0] mode_of(
        input aivf_pkg::aivf_state_s s,
        input logic [1:0] pair
    );
        mode_of = s.rec1[aivf_pkg::IDX_MODE0 + 4'(pair)][7:4];
    endfunction

    // temperature types are converted in full format
    function automatic logic is_temp(input logic [3:0] mt);
        is_temp = !(mt == aivf_pkg::MT_VOLT || mt == aivf_pkg::MT_CUR4 ||
                    mt == aivf_pkg::MT_CUR2 || mt == aivf_pkg::MT_RES);
    endfunction

    // mask that clears the low bits at a given interference frequency
    function automatic logic [15:0] trunc_mask(input logic [1:0] fc);
        unique case (fc)
            aivf_pkg::FREQ_10: trunc_mask = aivf_pkg::MASK_10;  // RULE_05
            aivf_pkg::FREQ_50,
            aivf_pkg::FREQ_60: trunc_mask = aivf_pkg::MASK_50;  // RULE_06
            aivf_pkg::FREQ_400: trunc_mask = aivf_pkg::MASK_400; // RULE_07
        endcase
    endfunction

    // signed add that clips to the word limits
    function automatic logic [15:0] sat_add(
        input logic [15:0] a,
        input logic [15:0] b
    );
        logic [16:0] sum;
        sum = {a[15], a} + {b[15], b};
        if (sum[16] != sum[15]) begin
            sat_add = sum[16] ? aivf_pkg::SAT_NEG : aivf_pkg::SAT_POS;
        end else begin
            sat_add = sum[15:0];
        end
    endfunction

    // two-byte limit held high byte first
    function automatic logic [15:0] limit_at(
        input aivf_pkg::aivf_state_s s,
        input logic [3:0] idx
    );
        limit_at = {s.rec1[idx], s.rec1[idx + 4'h1]};
    endfunction

    // parameter writes, read-back and the formatting pipeline
    always_comb begin
        logic [1:0] pair;
        logic [3:0] mt;
        logic [1:0] fc;
        logic [15:0] val;
        logic flag;
        logic [15:0] up;
        logic [15:0] lo;
        pair = head.chan[2:1];
        mt = mode_of(s_r, pair);
        fc = s_r.rec1[aivf_pkg::IDX_FREQ][2 * pair +: 2]; // RULE_19
        val = head.value;
        flag = 1'b0;
        up = '0;
        lo = '0;
        s_nxt = s_r;
        s_nxt.proc_irq = 1'b0;
        s_nxt.diag_irq = 1'b0;

        // first record only from the configuration transfer; runtime
        // calls reach the second record alone
        if (prm_wr && !prm_set && !prm_runtime) begin // RULE_14
            if (prm_idx < 4'(aivf_pkg::REC0_BYTES)) begin
                // reserved and absent pairs read back as zero
                s_nxt.rec0[prm_idx[0]] = prm_data & PAIR_MASK; // RULE_15
            end
        end else if (prm_wr && prm_set) begin
            if (prm_idx == aivf_pkg::IDX_FREQ) begin
                // settings of absent pairs are dropped
                s_nxt.rec1[prm_idx] = (prm_data & FREQ_MASK) |
                    (s_r.rec1[prm_idx] & ~FREQ_MASK); // RULE_12
            end else if (prm_idx >= aivf_pkg::IDX_MODE0 &&
                         prm_idx < aivf_pkg::IDX_UP0) begin
                if (prm_idx - aivf_pkg::IDX_MODE0 < 4'(NUM_PAIRS)) begin
                    s_nxt.rec1[prm_idx] = prm_data; // RULE_12
                end
            end else if (prm_idx < 4'(aivf_pkg::REC1_BYTES)) begin
                s_nxt.rec1[prm_idx] = prm_data; // RULE_20
            end
        end

        // read-back of both records and the diagnosis state
        unique case (rd_set)
            aivf_pkg::RD_REC0: s_nxt.rd_data = s_r.rec0[rd_idx[0]];
            aivf_pkg::RD_REC1: s_nxt.rd_data =
                (rd_idx < 4'(aivf_pkg::REC1_BYTES)) ? s_r.rec1[rd_idx] : '0;
            aivf_pkg::RD_STAT: s_nxt.rd_data = {4'h0, s_r.diag_flags};
            default: s_nxt.rd_data = '0;
        endcase

        if (s_r.out_valid && out_ready) begin
            s_nxt.out_valid = 1'b0;
        end

        if (fifo_valid && fifo_ready) begin
            // saturation is decided first so clipped codes stay whole
            if ((mt == aivf_pkg::MT_RTD || mt == aivf_pkg::MT_REFJ) &&
                head.chan[0]) begin
                val = aivf_pkg::SAT_POS; // RULE_02
            end else if (head.over) begin
                val = aivf_pkg::SAT_POS; // RULE_09 RULE_21
            end else if (head.under) begin
                val = aivf_pkg::SAT_NEG; // RULE_10 RULE_21
            end else if (mt == aivf_pkg::MT_REFJ && head.wire_break) begin
                val = aivf_pkg::SAT_POS; // RULE_03
            end else if (mt == aivf_pkg::MT_TC_EXT) begin
                // a broken reference poisons every compensated channel
                val = (s_r.refj == aivf_pkg::SAT_POS) ? aivf_pkg::SAT_POS :
                      sat_add(head.value, s_r.refj); // RULE_03
            end else if (!is_temp(mt)) begin
                val = head.value & trunc_mask(fc); // RULE_08
            end
            if (mt == aivf_pkg::MT_REFJ && !head.chan[0]) begin
                s_nxt.refj = val; // RULE_01
            end
            s_nxt.out_valid = 1'b1;
            s_nxt.out_chan = head.chan;
            s_nxt.out_value = val; // RULE_04

            // per-pair diagnosis, gated by the first record
            flag = s_r.rec0[aivf_pkg::IDX_GRP][pair] &&
                   (head.over || head.under ||
                    (head.wire_break &&
                     s_r.rec0[aivf_pkg::IDX_WB][pair])); // RULE_16 RULE_18
            s_nxt.diag_flags[pair] = flag; // RULE_15
            s_nxt.diag_irq = flag &&
                s_r.rec1[aivf_pkg::IDX_IRQ][aivf_pkg::DIAG_IRQ_BIT]; // RULE_20

            // limits exist for channels 0 and 2 only
            if (head.chan == 3'h0 || head.chan == 3'h2) begin
                up = limit_at(s_r, head.chan[1] ? aivf_pkg::IDX_UP2 :
                              aivf_pkg::IDX_UP0);
                lo = limit_at(s_r, head.chan[1] ? aivf_pkg::IDX_LO2 :
                              aivf_pkg::IDX_LO0);
                s_nxt.proc_irq =
                    s_r.rec1[aivf_pkg::IDX_IRQ][aivf_pkg::PROC_IRQ_BIT] &&
                    ($signed(val) > $signed(up) ||
                     $signed(val) < $signed(lo)); // RULE_17
            end
        end
    end

    // power-on values: +/-10V, 50Hz, diagnostics and interrupts off
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= RST_STATE; // RULE_11
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rd_data;
    assign out_valid = s_r.out_valid;
    assign out_chan = s_r.out_chan;
    assign out_value = s_r.out_value;
    assign proc_irq = s_r.proc_irq;
    assign diag_irq = s_r.diag_irq;
    assign diag_flags = s_r.diag_flags;
endmodule

`default_nettype wire

// [verification/aivf_chk_sva.sv]
// port assertions for the analog value formatter
`timescale 1ns/1ps
`default_nettype none
module aivf_chk #(
    parameter int NUM_PAIRS = 4,  // pairs in use
    parameter int FIFO_DEPTH = 32 // buffer depth
) (
    input wire logic clock,            // system clock
    input wire logic nrst,             // reset, active low
    input wire logic [1:0] rd_set,     // read selector
    input wire logic [7:0] rd_data,    // read-back byte
    input wire logic raw_valid,        // raw offered
    input wire logic raw_ready,        // buffer room
    input wire logic out_valid,        // word valid
    input wire logic out_ready,        // word taken
    input wire logic [2:0] out_chan,   // word channel
    input wire logic [15:0] out_value, // word value
    input wire logic proc_irq,         // limit pulse
    input wire logic diag_irq,         // diagnosis pulse
    input wire logic [3:0] diag_flags  // pair state
);
    logic [7:0] inflight_r; // words taken but not yet delivered
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // counted at the ports, so no body knowledge is needed
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            inflight_r <= 8'h00;
        end else begin
            inflight_r <= inflight_r + 8'(raw_valid && raw_ready)
                - 8'(out_valid && out_ready);
        end
    end
    sequence held_s;
        out_valid && !out_ready;
    endsequence
    sequence kept_s;
        out_valid && $stable(out_value) && $stable(out_chan);
    endsequence
    AST_HOLD: assert property (held_s |=> kept_s)
        else $error("word changed while stalled");
    AST_REC0_RSVD: assert property (
        rd_set == aivf_pkg::RD_REC0 |=> rd_data[7:4] == 4'h0)
        else $error("reserved record bits not zero");
    AST_STATUS: assert property (
        rd_set == aivf_pkg::RD_STAT |=> rd_data == {4'h0, $past(diag_flags)})
        else $error("status read-back wrong");
    AST_NO_SEL: assert property (rd_set == 2'h3 |=> rd_data == 8'h00)
        else $error("unused selector not zero");
    AST_PROC_CH: assert property (
        proc_irq |-> out_valid && (out_chan == 3'h0 || out_chan == 3'h2))
        else $error("limit pulse on wrong channel");
    AST_PROC_ONCE: assert property (
        proc_irq && !out_ready |=> !proc_irq)
        else $error("limit pulse repeated on held word");
    AST_DIAG: assert property (
        diag_irq |-> out_valid && diag_flags[out_chan[2:1]])
        else $error("diagnosis pulse without pair flag");
    AST_PHANTOM: assert property (out_valid |-> inflight_r != 8'h00)
        else $error("word out without word in");
    AST_FULL: assert property (!raw_ready |-> inflight_r >= 8'(FIFO_DEPTH))
        else $error("input refused before buffer full");
endmodule
bind aivf_top aivf_chk #(.NUM_PAIRS(NUM_PAIRS), .FIFO_DEPTH(FIFO_DEPTH))
    u_chk (.clock, .nrst, .rd_set, .rd_data, .raw_valid, .raw_ready,
    .out_valid, .out_ready, .out_chan, .out_value, .proc_irq, .diag_irq,
    .diag_flags);
`default_nettype wire

// [verification/aivf_cpu_model.sv]
// controller model that writes the parameter records
`timescale 1ns/1ps
`default_nettype none
module aivf_cpu_model (
    input wire logic clock,     // system clock
    output logic prm_wr,        // byte strobe
    output logic prm_set,       // record select
    output logic prm_runtime,   // runtime call flag
    output logic [3:0] prm_idx, // byte index
    output logic [7:0] prm_data // byte
);
    initial begin
        prm_wr = 1'b0;
        prm_set = 1'b0;
        prm_runtime = 1'b0;
        prm_idx = 4'h0;
        prm_data = 8'h00;
    end
    // one byte per strobe; data is scrambled once released
    task automatic put(input logic st, input logic rt, input logic [3:0] idx,
        input logic [7:0] d);
        @(posedge clock);
        #1 prm_wr = 1'b1;
        {prm_set, prm_runtime, prm_idx, prm_data} = {st, rt, idx, d};
        @(posedge clock);
        #1 prm_wr = 1'b0;
        prm_data = ~d;
    endtask
    // stop to run: whole 16-byte area, runtime flag low
    task automatic to_run(input logic [15:0][7:0] rec);
        for (int i = 0; i < 16; i++) begin
            put(i >= 2, 1'b0, 4'(i < 2 ? i : i - 2), rec[i]);
        end
    endtask
    // runtime call: second record only
    task automatic runtime(input logic [3:0] idx, input logic [7:0] d);
        put(1'b1, 1'b1, idx, d);
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the analog value formatter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, nrst, raw_valid, out_ready, raw_ready, out_valid;
    logic prm_wr, prm_set, prm_runtime, proc_irq, diag_irq, pi, di;
    logic [1:0] rd_set;
    logic [3:0] rd_idx, prm_idx, diag_flags;
    logic [7:0] prm_data, rd_data, rd_data2;
    logic [2:0] out_chan;
    logic [15:0] out_value;
    aivf_pkg::aivf_raw_s raw;
    int fails, compares, taken, got;
    aivf_cpu_model cpu (.clock, .prm_wr, .prm_set, .prm_runtime, .prm_idx,
        .prm_data);
    aivf_top DUT (.clock, .nrst, .prm_wr, .prm_set, .prm_runtime, .prm_idx,
        .prm_data, .rd_set, .rd_idx, .rd_data, .raw_valid, .raw_ready, .raw,
        .out_valid, .out_ready, .out_chan, .out_value, .proc_irq, .diag_irq,
        .diag_flags);
    // two-channel variant shares every input
    aivf_top #(.NUM_PAIRS(1)) DUT2 (.clock, .nrst, .prm_wr, .prm_set,
        .prm_runtime, .prm_idx, .prm_data, .rd_set, .rd_idx,
        .rd_data(rd_data2), .raw_valid, .raw_ready(), .raw, .out_valid(),
        .out_ready, .out_chan(), .out_value(), .proc_irq(), .diag_irq(),
        .diag_flags());
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd(input logic [1:0] st, input logic [3:0] i,
        input logic [7:0] exp);
        @(posedge clock);
        #1 rd_set = st;
        rd_idx = i;
        @(posedge clock);
        #1 check({8'h00, rd_data}, {8'h00, exp});
    endtask
    // one raw sample through to the formatted word; flags over,under,break
    task automatic smp(input logic [2:0] ch, input logic [15:0] v,
        input logic [2:0] f, input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        #1 raw = {ch, v, f};
        raw_valid = 1'b1;
        @(posedge clock);
        while (raw_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        #1 raw_valid = 1'b0;
        raw = ~raw;
        while (out_valid !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 50) begin
            fails++;
            wrap_up();
        end
        check(out_value, exp);
        check({13'h0, out_chan}, {13'h0, ch});
        pi = proc_irq;
        di = diag_irq;
        // one stall cycle so the hold and single-pulse checks see traffic
        @(posedge clock);
        #1 out_ready = 1'b1;
        @(posedge clock);
        #1 out_ready = 1'b0;
    endtask
    function automatic logic [15:0] mask(input int code);
        return code == 0 ? 16'hFFC0 : (code == 3 ? 16'hFFFE : 16'hFFF8);
    endfunction
    initial begin
        {fails, compares, nrst, raw_valid, out_ready} = '0;
        {rd_set, rd_idx, raw} = '0;
        repeat (6) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clock);
        rd(2'h0, 4'h0, 8'h00);
        rd(2'h0, 4'h1, 8'h00);
        rd(2'h1, 4'h0, 8'h00);
        rd(2'h1, 4'h1, 8'hAA);
        rd(2'h1, 4'h2, 8'h19);
        cpu.put(1'b0, 1'b1, 4'h0, 8'h0F);
        rd(2'h0, 4'h0, 8'h00);
        cpu.to_run(128'h0080_FF7F_0080_1000_1919_1919_AAC0_FF0F);
        rd(2'h0, 4'h0, 8'h0F);
        rd(2'h0, 4'h1, 8'h0F);
        rd(2'h1, 4'h0, 8'hC0);
        cpu.runtime(4'h3, 8'h40);
        rd(2'h1, 4'h3, 8'h40);
        check({8'h00, rd_data2}, 16'h0019);
        // every frequency code on pair 0, both signs
        for (int i = 0; i < 4; i++) begin
            cpu.runtime(4'h1, {6'h2A, 2'(i)});
            smp(3'h0, 16'h5557, 3'h0, 16'h5557 & mask(i));
            smp(3'h1, 16'hABCD, 3'h0, 16'hABCD & mask(i));
        end
        smp(3'h0, 16'h0020, 3'h0, 16'h0020);
        check({15'h0, pi}, 16'h0001);
        smp(3'h0, 16'h0008, 3'h0, 16'h0008);
        check({15'h0, pi}, 16'h0000);
        // saturation must survive the coarsest truncation
        cpu.runtime(4'h1, 8'hA8);
        smp(3'h1, 16'h1234, 3'b010, 16'h8000);
        smp(3'h1, 16'h1234, 3'b100, 16'h7FFF);
        check({15'h0, di}, 16'h0001);
        check({12'h0, diag_flags}, 16'h0001);
        cpu.runtime(4'h3, 8'h80);
        smp(3'h2, 16'h1235, 3'h0, 16'h1235);
        smp(3'h3, 16'h1235, 3'h0, 16'h7FFF);
        cpu.runtime(4'h3, 8'hF0);
        cpu.runtime(4'h2, 8'hB0);
        smp(3'h2, 16'h0100, 3'h0, 16'h0100);
        smp(3'h3, 16'h0022, 3'h0, 16'h7FFF);
        smp(3'h0, 16'h0010, 3'h0, 16'h0110);
        smp(3'h2, 16'h0100, 3'b001, 16'h7FFF);
        smp(3'h0, 16'h0010, 3'h0, 16'h7FFF);
        rd(2'h2, 4'h0, 8'h02);
        rd(2'h3, 4'h0, 8'h00);
        // fill the buffer with the consumer stalled, then drain it
        @(posedge clock);
        #1 raw = {3'h1, 16'h0000, 3'h0};
        raw_valid = 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(posedge clock);
            if (raw_ready !== 1'b1) break;
            taken++;
        end
        #1 raw_valid = 1'b0;
        check({15'h0, taken >= 32}, 16'h0001);
        out_ready = 1'b1;
        repeat (80) begin
            @(posedge clock);
            if (out_valid === 1'b1) got++;
        end
        check(16'(got), 16'(taken));
        wrap_up();
    end
endmodule
`default_nettype wire
